// >>> pkg/sdd_pkg.sv
`default_nettype none
package sdd_pkg;

  // ==========================================================================
  // Geometry.
  localparam int unsigned CHANNELS = 5;
  localparam int unsigned SAMPLE_W = 12;
  localparam int unsigned TIMER_W = 24;
  localparam int unsigned RUN_W = 2;

  // ==========================================================================
  // Timing, as figures in their own units and as cycle counts at the clock rate.
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned SAMPLE_PERIOD_US = 72;
  localparam int unsigned BEGIN_MIN_US = 400;
  localparam int unsigned BEGIN_MAX_US = 600;
  localparam int unsigned WINDOW_MS = 56;
  localparam int unsigned SAMPLE_CYCLES = (SAMPLE_PERIOD_US * 1000 * 1000) / CLK_PERIOD_PS;
  localparam int unsigned BEGIN_CYCLES = (BEGIN_MIN_US * 1000 * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned WINDOW_CYCLES = (WINDOW_MS * 1000 * 1000) / (CLK_PERIOD_PS / 1000);

  // ==========================================================================
  // Voltage thresholds in sample codes; one code step stands for 0.5 mV.
  localparam int unsigned LSB_UV = 500;
  localparam int unsigned RISE_UV = 500;
  localparam int unsigned FALL_UV = 3000;
  localparam logic [SAMPLE_W:0] RISE_CODE = (SAMPLE_W + 1)'(RISE_UV / LSB_UV);
  localparam logic [SAMPLE_W:0] FALL_CODE = (SAMPLE_W + 1)'(FALL_UV / LSB_UV);
  localparam logic [SAMPLE_W-1:0] NEAR_GND_CODE = 12'h064;
  localparam logic [RUN_W-1:0] RUN_LEN = 2'h3;

  // ==========================================================================
  // Per-channel detector state.
  typedef enum logic [2:0] {
    SDD_IDLE,
    SDD_QUALIFY,
    SDD_PRE_DIP,
    SDD_DIP_SEARCH,
    SDD_POST_DIP
  } sdd_phase_e;

  typedef struct packed {
    sdd_phase_e phase;
    logic [SAMPLE_W-1:0] level_ref;
    logic [SAMPLE_W-1:0] prev;
    logic [TIMER_W-1:0] window;
    logic [TIMER_W-1:0] qualify;
    logic [RUN_W-1:0] run;
    logic fault;
    logic active;
  } sdd_chan_s;

endpackage
`default_nettype wire

// >>> logic/sdd_sync.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================================
// Two-stage synchroniser for inputs from outside the clock domain.
module sdd_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic I_CLK,
  input wire logic I_RESETN,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sdd_sync_s;

  sdd_sync_s state;
  sdd_sync_s next_state;

  always_comb begin
    next_state.meta = i_async;
    next_state.stable = state.meta;
  end

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      // Ones read as a driver switched off, so leaving reset never looks like
      // a drop to near ground on any channel.
      state <= '1;
    end else begin
      state <= next_state;
    end
  end

  assign o_sync = state.stable;

endmodule
`default_nettype wire

// >>> logic/sdd_top.sv
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - After the run of descending samples, keep sampling and auto-zeroing while searching for the dip inflection.
// - If no dip is found before the 56 ms window from activation runs out, set the channel's fault bit to one.
// - A dip found inside the window raises no fault and moves the channel on to post-dip sampling.
// - Post-dip sampling lasts until the third consecutive rise or for whatever remains of the same 56 ms window begun at activation.
// - Three post-dip sample periods of continued rise mark the solenoid operational and clear the fault bit.
// - Once the post-dip evaluation ends, the channel returns to idle and waits for the next activation.
// - One sample is taken every 72 us and compared with the previous reference level.
// - A sample at least 0.5 mV above the reference auto-zeroes the reference to the new level.
// - Past the peak, no auto-zero happens until three consecutive falls of at least 3 mV, which start the dip search.
// - A drop to near ground starts a 400 us qualify timer, and analysis starts only if still near ground at its end.
module sdd_top #(
  parameter int unsigned SAMPLE_CYCLES = sdd_pkg::SAMPLE_CYCLES,
  parameter int unsigned BEGIN_CYCLES = sdd_pkg::BEGIN_CYCLES,
  parameter int unsigned WINDOW_CYCLES = sdd_pkg::WINDOW_CYCLES
) (
  input wire logic I_CLK,
  input wire logic I_RESETN,
  input wire logic [sdd_pkg::CHANNELS-1:0][sdd_pkg::SAMPLE_W-1:0] I_CHANNEL_SENSE_INPUTS,
  output logic [sdd_pkg::CHANNELS-1:0] O_FAULT,
  output logic [sdd_pkg::CHANNELS-1:0] O_ACTIVE,
  output logic O_SAMPLE_TICK
);

  // ==========================================================================
  // Slope tests shared by the analysis phases of the detector; idle and qualify use neither.
  function automatic logic rose(input logic [sdd_pkg::SAMPLE_W-1:0] now,
                                input logic [sdd_pkg::SAMPLE_W-1:0] base);
    rose = {1'b0, now} >= ({1'b0, base} + sdd_pkg::RISE_CODE);
  endfunction

  function automatic logic fell(input logic [sdd_pkg::SAMPLE_W-1:0] now,
                                input logic [sdd_pkg::SAMPLE_W-1:0] base);
    fell = ({1'b0, now} + sdd_pkg::FALL_CODE) <= {1'b0, base};
  endfunction

  // ==========================================================================
  // Input synchronisation.
  // The sample words cross as whole buses; idle and qualify test them every cycle, the analysis
  // phases only on a sample tick, long after any input change has settled through both stages.
  logic [sdd_pkg::CHANNELS*sdd_pkg::SAMPLE_W-1:0] sense_sync;

  sdd_sync #(
    .WIDTH(sdd_pkg::CHANNELS * sdd_pkg::SAMPLE_W)
  ) u_sync (
    .I_CLK(I_CLK),
    .I_RESETN(I_RESETN),
    .i_async(I_CHANNEL_SENSE_INPUTS),
    .o_sync(sense_sync)
  );

  // ==========================================================================
  // State.
  typedef struct packed {
    sdd_pkg::sdd_chan_s [sdd_pkg::CHANNELS-1:0] ch;
    logic [sdd_pkg::TIMER_W-1:0] tick_cnt;
    logic tick;
  } sdd_top_s;

  sdd_top_s state;
  sdd_top_s next_state;

  localparam logic [sdd_pkg::TIMER_W-1:0] SAMPLE_LAST = sdd_pkg::TIMER_W'(SAMPLE_CYCLES - 1);
  localparam logic [sdd_pkg::TIMER_W-1:0] BEGIN_LAST = sdd_pkg::TIMER_W'(BEGIN_CYCLES - 1);
  localparam logic [sdd_pkg::TIMER_W-1:0] WINDOW_LAST = sdd_pkg::TIMER_W'(WINDOW_CYCLES - 1);
  localparam logic [sdd_pkg::TIMER_W-1:0] TIMER_ONE = sdd_pkg::TIMER_W'(1);
  localparam logic [sdd_pkg::RUN_W-1:0] RUN_ONE = sdd_pkg::RUN_W'(1);

  // ==========================================================================
  // Next state, one detector per channel.
  always_comb begin
    logic [sdd_pkg::SAMPLE_W-1:0] s;
    logic near_gnd;
    logic expired;
    s = '0;
    near_gnd = 1'b0;
    expired = 1'b0;
    next_state = state;

    // A free-running sample clock shared by all channels keeps the sample
    // instants aligned; each channel therefore starts up to one period late.
    next_state.tick = 1'b0;
    if (state.tick_cnt == SAMPLE_LAST) begin
      next_state.tick_cnt = '0;
      next_state.tick = 1'b1;
    end else begin
      next_state.tick_cnt = state.tick_cnt + TIMER_ONE;
    end

    for (int i = 0; i < sdd_pkg::CHANNELS; i++) begin
      s = sense_sync[i*sdd_pkg::SAMPLE_W +: sdd_pkg::SAMPLE_W];
      near_gnd = s <= sdd_pkg::NEAR_GND_CODE;
      expired = state.ch[i].window == WINDOW_LAST;
      // The window counter stops at its last value, so a channel held past
      // expiry cannot wrap round into a fresh window.
      if (state.ch[i].phase != sdd_pkg::SDD_IDLE && !expired) begin
        next_state.ch[i].window = state.ch[i].window + TIMER_ONE;
      end

      unique case (state.ch[i].phase)
        sdd_pkg::SDD_IDLE: begin
          // Counters are cleared while idle rather than on exit, so every
          // activation starts from a clean window and an empty run.
          next_state.ch[i].window = '0;
          next_state.ch[i].qualify = '0;
          next_state.ch[i].run = '0;
          if (near_gnd) begin
            next_state.ch[i].phase = sdd_pkg::SDD_QUALIFY;
          end
        end

        sdd_pkg::SDD_QUALIFY: begin
          // One sample above the near-ground level aborts qualification; there
          // is no glitch filter, so a noisy drain only delays activation.
          if (!near_gnd) begin
            next_state.ch[i].phase = sdd_pkg::SDD_IDLE;
          end else if (state.ch[i].qualify == BEGIN_LAST) begin
            next_state.ch[i].phase = sdd_pkg::SDD_PRE_DIP;
            next_state.ch[i].level_ref = s;
            next_state.ch[i].prev = s;
          end else begin
            next_state.ch[i].qualify = state.ch[i].qualify + TIMER_ONE;
          end
        end

        sdd_pkg::SDD_PRE_DIP: begin
          // Expiry is tested ahead of the tick, so a sample on the last window
          // cycle cannot overturn the fault verdict.
          if (expired) begin
            next_state.ch[i].fault = 1'b1;
            next_state.ch[i].phase = sdd_pkg::SDD_IDLE;
          end else if (state.tick) begin
            next_state.ch[i].prev = s;
            if (fell(s, state.ch[i].prev)) begin
              // The reference is held through the first two falls; the third loads it for the dip search.
              next_state.ch[i].run = state.ch[i].run + RUN_ONE;
              if (state.ch[i].run == sdd_pkg::RUN_LEN - RUN_ONE) begin
                next_state.ch[i].phase = sdd_pkg::SDD_DIP_SEARCH;
                next_state.ch[i].level_ref = s;
                next_state.ch[i].run = '0;
              end
            end else begin
              next_state.ch[i].run = '0;
              if (rose(s, state.ch[i].level_ref)) begin
                next_state.ch[i].level_ref = s;
              end
            end
          end
        end

        sdd_pkg::SDD_DIP_SEARCH: begin
          if (expired) begin
            next_state.ch[i].fault = 1'b1;
            next_state.ch[i].phase = sdd_pkg::SDD_IDLE;
          end else if (state.tick) begin
            next_state.ch[i].prev = s;
            next_state.ch[i].level_ref = s;
            if (rose(s, state.ch[i].level_ref)) begin
              // Slope turned from falling to rising: the armature dip.
              next_state.ch[i].phase = sdd_pkg::SDD_POST_DIP;
              next_state.ch[i].run = '0;
            end
          end
        end

        sdd_pkg::SDD_POST_DIP: begin
          if (expired) begin
            // A channel that never showed the post-dip rise is not trusted.
            next_state.ch[i].fault = 1'b1;
            next_state.ch[i].phase = sdd_pkg::SDD_IDLE;
          end else if (state.tick) begin
            next_state.ch[i].prev = s;
            if (rose(s, state.ch[i].level_ref)) begin
              next_state.ch[i].level_ref = s;
              next_state.ch[i].run = state.ch[i].run + RUN_ONE;
              if (state.ch[i].run == sdd_pkg::RUN_LEN - RUN_ONE) begin
                next_state.ch[i].fault = 1'b0;
                next_state.ch[i].phase = sdd_pkg::SDD_IDLE;
              end
            end else begin
              // A flat or falling sample restarts the count: the rises must be consecutive.
              next_state.ch[i].run = '0;
            end
          end
        end

        default: begin
          next_state.ch[i].phase = sdd_pkg::SDD_IDLE;
        end
      endcase

      // The active flag follows the analysis phases directly, so it drops on the
      // same edge that settles the fault bit.
      next_state.ch[i].active = next_state.ch[i].phase inside {sdd_pkg::SDD_PRE_DIP,
                                                             sdd_pkg::SDD_DIP_SEARCH,
                                                             sdd_pkg::SDD_POST_DIP};
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // Outputs straight from the state flops.
  // Nothing combinational sits between the state register and the pins.
  always_comb begin
    for (int i = 0; i < sdd_pkg::CHANNELS; i++) begin
      O_FAULT[i] = state.ch[i].fault;
      O_ACTIVE[i] = state.ch[i].active;
    end
    O_SAMPLE_TICK = state.tick;
  end

endmodule
`default_nettype wire

// >>> sim/sdd_top_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================================
// Port checker. Channel 0 is followed in detail; the vector checks cover every channel.
module sdd_top_chk #(
  parameter int unsigned SAMPLE_CYCLES = 14400,
  parameter int unsigned BEGIN_CYCLES = 80000,
  parameter int unsigned WINDOW_CYCLES = 11200000
) (
  input wire logic I_CLK,
  input wire logic I_RESETN,
  input wire logic [4:0][11:0] I_CHANNEL_SENSE_INPUTS,
  input wire logic [4:0] O_FAULT,
  input wire logic [4:0] O_ACTIVE,
  input wire logic O_SAMPLE_TICK
);
  localparam int unsigned SPAN = WINDOW_CYCLES - BEGIN_CYCLES;
  logic [23:0] gap, gnd, on;
  logic [11:0] last;
  logic [2:0] ups;
  logic seen;
  logic [4:0] near;
  always_comb
    for (int i = 0; i < 5; i++) near[i] = I_CHANNEL_SENSE_INPUTS[i] <= sdd_pkg::NEAR_GND_CODE;
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      gap <= '0;
      gnd <= '0;
      on <= '0;
      last <= '0;
      ups <= '0;
      seen <= 1'b0;
    end else begin
      gap <= O_SAMPLE_TICK ? 24'h0 : gap + 24'h1;
      gnd <= near[0] ? gnd + 24'h1 : 24'h0;
      on <= O_ACTIVE[0] ? on + 24'h1 : 24'h0;
      seen <= seen | O_SAMPLE_TICK;
      if (O_SAMPLE_TICK) begin
        last <= I_CHANNEL_SENSE_INPUTS[0];
        ups <= (I_CHANNEL_SENSE_INPUTS[0] > last) ? ups + {2'h0, ups != 3'h7} : 3'h0;
      end
    end
  end
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RESETN);
  sequence s_done;
    $fell(O_ACTIVE[0]) ##0 !O_FAULT[0];
  endsequence
  property p_tick; seen |-> (O_SAMPLE_TICK == (gap == SAMPLE_CYCLES - 1)); endproperty
  property p_qual; $rose(O_ACTIVE[0]) |-> gnd >= BEGIN_CYCLES; endproperty
  property p_own; (O_ACTIVE & ~$past(O_ACTIVE) & ~$past(near, 3)) == 5'h00; endproperty
  property p_end; ((O_FAULT ^ $past(O_FAULT)) & ~($past(O_ACTIVE) & ~O_ACTIVE)) == 5'h00; endproperty
  property p_idle; $fell(O_ACTIVE[0]) |=> !O_ACTIVE[0] [*8]; endproperty
  property p_expire; $rose(O_FAULT[0]) |-> on + 3 >= SPAN && on <= SPAN + 3; endproperty
  property p_early; s_done |-> on + 3 < SPAN; endproperty
  property p_rise; s_done |-> ups >= 3'h3; endproperty
  a_tick: assert property (p_tick) else $error("tick period wrong");
  a_qual: assert property (p_qual) else $error("activation too early");
  a_own: assert property (p_own) else $error("channel woke without own input");
  a_end: assert property (p_end) else $error("fault moved outside evaluation end");
  a_idle: assert property (p_idle) else $error("no return to idle");
  a_expire: assert property (p_expire) else $error("fault not at window end");
  a_early: assert property (p_early) else $error("pass after window");
  a_rise: assert property (p_rise) else $error("pass without rises");
endmodule
bind sdd_top sdd_top_chk #(.SAMPLE_CYCLES(SAMPLE_CYCLES), .BEGIN_CYCLES(BEGIN_CYCLES),
  .WINDOW_CYCLES(WINDOW_CYCLES)) u_chk (.I_CLK(I_CLK), .I_RESETN(I_RESETN),
  .I_CHANNEL_SENSE_INPUTS(I_CHANNEL_SENSE_INPUTS), .O_FAULT(O_FAULT), .O_ACTIVE(O_ACTIVE),
  .O_SAMPLE_TICK(O_SAMPLE_TICK));
`default_nettype wire

// >>> sim/sdd_partner.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================================
// Drain voltage of five driven solenoids, stepped once per sample period.
module sdd_partner (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_tick,
  input wire logic [4:0] i_go,
  input wire logic [4:0] i_good,
  output logic [4:0][11:0] o_sense
);
  logic [4:0][4:0] k;
  // Near ground for four to five periods so qualification ends whatever the tick phase.
  // A stuck armature never shows the rise after the dip.
  function automatic logic [11:0] level(input logic [4:0] n, input logic ok);
    if (n < 5'd5) return 12'h010;
    if (n < 5'd9) return 12'h010 + 12'(n - 5'd4) * 12'h080;
    if (n < 5'd12) return 12'h210 - 12'(n - 5'd8) * 12'h020;
    return ok ? 12'h1b0 + 12'(n - 5'd11) * 12'h008 : 12'h1b0;
  endfunction
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      k <= '0;
      o_sense <= {5{12'hfff}};
    end else begin
      for (int i = 0; i < 5; i++) begin
        k[i] <= !i_go[i] ? 5'd0 : k[i] + {4'd0, i_tick && k[i] != 5'd31};
        o_sense[i] <= i_go[i] ? level(k[i], i_good[i]) : 12'hfff;
      end
    end
  end
endmodule
`default_nettype wire

// >>> sim/solenoid_dip_detector_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================================
// Random activation rounds; the fault vector is checked once every channel settles.
module solenoid_dip_detector_tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [4:0] go = 5'h00, good = 5'h00, want = 5'h00, go_v, ok_v, flt, act;
  logic [4:0][11:0] sense;
  logic tick;
  logic busy = 1'b0;
  int seed = 58;
  int fails = 0;
  int tests_run = 0;
  logic [4:0] notes[$];
  always #2.5 clk = ~clk;
  sdd_top #(.SAMPLE_CYCLES(8), .BEGIN_CYCLES(20), .WINDOW_CYCLES(400)) uut (.I_CLK(clk), .I_RESETN(rstn),
    .I_CHANNEL_SENSE_INPUTS(sense), .O_FAULT(flt), .O_ACTIVE(act), .O_SAMPLE_TICK(tick));
  sdd_partner far (.i_clk(clk), .i_resetn(rstn), .i_tick(tick), .i_go(go), .i_good(good), .o_sense(sense));
  task automatic chk(input logic [4:0] got, input logic [4:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(negedge clk) begin
    if (busy && act === 5'h00 && notes.size() != 0) chk(flt, notes.pop_front());
    busy = |act;
  end
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    for (int r = 0; r < 10; r++) begin
      if (r == 6) begin
        rstn <= 1'b0;
        @(negedge clk);
        chk(flt, 5'h00);
        @(posedge clk);
        rstn <= 1'b1;
        want = 5'h00;
      end
      @(posedge clk);
      // Round 0 fails every channel and round 1 clears every one; the rest mix.
      go_v = (r < 2) ? 5'h1f : 5'($random(seed)) | 5'h01;
      ok_v = (r == 0) ? 5'h00 : (r == 1) ? 5'h1f : 5'($random(seed));
      want = (want & ~go_v) | (go_v & ~ok_v);
      notes.push_back(want);
      go <= go_v;
      good <= ok_v;
      for (int n = 0; n < 600 && notes.size() != 0; n++) @(posedge clk);
      go <= 5'h00;
      repeat (4) @(posedge clk);
    end
    chk(5'(notes.size()), 5'h00);
    give_verdict();
  end
  initial begin
    #40000;
    fails++;
    give_verdict();
  end
endmodule
`default_nettype wire
